//--- design/mie_exec_top.sv
// Function
// - Clear register: data zero, zero flag set
// - Invert register, zero flag from result
// - Destination bit: 0 accumulator, 1 register
// - Watchdog clear; prescaler too when assigned
// - Watchdog clear sets timeout and powerdown flags
// - Compare: register minus accumulator, Z and C
// - Compare keeps accumulator and register unchanged
// - Decimal adjust accumulator after addition, carry
// - Decrement register, route result, test zero
// - Zero result cancels next fetched instruction
// - Decrement-skip: one cycle, two when skipping
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module mie_exec_top
	import mie_pkg::*;
#(
	parameter int WDT_W = 16,
	parameter int PRE_W = 8
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);

	if (WDT_W < 2 || WDT_W > 16 || PRE_W < 1 || PRE_W > 16) begin : g_bad_width
		$error("mie_exec_top: counter width out of range");
	end

	function automatic mie_sel_type decode(
		input logic [AXI_ADDR_W-1:0] addr);
		mie_sel_type sel;
		sel = SEL_NONE;
		if (addr == OFF_INSTR) begin
			sel = SEL_INSTR;
		end else if (addr == OFF_ACC) begin
			sel = SEL_ACC;
		end else if (addr == OFF_STATUS) begin
			sel = SEL_STATUS;
		end else if (addr == OFF_OPTION) begin
			sel = SEL_OPTION;
		end else if (addr == OFF_WDT) begin
			sel = SEL_WDT;
		end else if (addr == OFF_EXEC) begin
			sel = SEL_EXEC;
		end else if (addr[AXI_ADDR_W-1:FILE_WIN_LSB] == FILE_WINDOW &&
			addr[FILE_IDX_LSB-1:0] == 2'h0) begin
			sel = SEL_FILE;
		end
		return sel;
	endfunction

	logic [7:0] file_mem [0:(1<<FILE_AW)-1];
	mie_state_type state_reg, state_next;
	logic [7:0] acc_reg, acc_next;
	logic c_reg, c_next, dc_reg, dc_next, z_reg, z_next;
	logic to_n_reg, to_n_next, pd_n_reg, pd_n_next;
	logic psa_reg, psa_next, skip_reg, skip_next;
	logic nop_reg, nop_next;
	logic [1:0] cycles_reg, cycles_next;
	logic [2:0] op_reg, op_next;
	logic dest_reg, dest_next;
	logic [FILE_AW-1:0] addr_reg, addr_next;
	logic [WDT_W-1:0] wdt_reg, wdt_next;
	logic [PRE_W-1:0] pre_reg, pre_next;
	logic mem_we;
	logic [FILE_AW-1:0] mem_addr;
	logic [7:0] mem_data, reg_val, alu_res;
	logic alu_c, alu_dc, res_zero, wdt_tick;
	logic wr_en, wr_err, rd_err;
	logic [AXI_ADDR_W-1:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	mie_sel_type wr_sel, rd_sel;

	assign reg_val = file_mem[addr_reg];
	assign res_zero = (alu_res == BYTE_ZERO);

	mie_axil_slave u_bus (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.s_axi_awaddr_in(s_axi_awaddr_in),
		.s_axi_awvalid_in(s_axi_awvalid_in),
		.s_axi_awready_out(s_axi_awready_out),
		.s_axi_wdata_in(s_axi_wdata_in),
		.s_axi_wstrb_in(s_axi_wstrb_in),
		.s_axi_wvalid_in(s_axi_wvalid_in),
		.s_axi_wready_out(s_axi_wready_out),
		.s_axi_bresp_out(s_axi_bresp_out),
		.s_axi_bvalid_out(s_axi_bvalid_out),
		.s_axi_bready_in(s_axi_bready_in),
		.s_axi_araddr_in(s_axi_araddr_in),
		.s_axi_arvalid_in(s_axi_arvalid_in),
		.s_axi_arready_out(s_axi_arready_out),
		.s_axi_rdata_out(s_axi_rdata_out),
		.s_axi_rresp_out(s_axi_rresp_out),
		.s_axi_rvalid_out(s_axi_rvalid_out),
		.s_axi_rready_in(s_axi_rready_in),
		.hold_in(state_reg != ST_IDLE),
		.wr_en_out(wr_en),
		.wr_addr_out(wr_addr),
		.wr_data_out(wr_data),
		.wr_strb_out(wr_strb),
		.wr_err_in(wr_err),
		.rd_addr_out(rd_addr),
		.rd_data_in(rd_data),
		.rd_err_in(rd_err)
	);

	mie_alu u_alu (
		.op_in(op_reg),
		.reg_in(reg_val),
		.acc_in(acc_reg),
		.c_in(c_reg),
		.dc_in(dc_reg),
		.result_out(alu_res),
		.c_out(alu_c),
		.dc_out(alu_dc)
	);

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_sel = decode(rd_addr);
		wr_sel = decode(wr_addr);
		wr_err = (wr_sel == SEL_NONE);
		rd_err = (rd_sel == SEL_NONE);
		rd_data = 32'h0000_0000;
		case (rd_sel)
		SEL_INSTR: begin
			rd_data[OPC_LSB+:OPC_W] = op_reg;
			rd_data[DEST_BIT] = dest_reg;
			rd_data[FILE_AW-1:0] = addr_reg;
		end
		SEL_ACC: rd_data[7:0] = acc_reg;
		SEL_STATUS: begin
			rd_data[ST_C_BIT] = c_reg;
			rd_data[ST_DC_BIT] = dc_reg;
			rd_data[ST_Z_BIT] = z_reg;
			rd_data[ST_PD_BIT] = pd_n_reg;
			rd_data[ST_TO_BIT] = to_n_reg;
		end
		SEL_OPTION: rd_data[OPT_PSA_BIT] = psa_reg;
		SEL_WDT: begin
			rd_data[WDT_W-1:0] = wdt_reg;
			rd_data[WDT_PRE_LSB+:PRE_W] = pre_reg;
		end
		SEL_EXEC: begin
			rd_data[EXEC_BUSY_BIT] = (state_reg != ST_IDLE);
			rd_data[EXEC_SKIP_BIT] = skip_reg;
			rd_data[EXEC_CYC_LSB+:2] = cycles_reg;
		end
		SEL_FILE: rd_data[7:0] = file_mem[rd_addr[FILE_IDX_LSB+:FILE_AW]];
		default: rd_data = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer, execution and watchdog
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		acc_next = acc_reg;
		c_next = c_reg;
		dc_next = dc_reg;
		z_next = z_reg;
		to_n_next = to_n_reg;
		pd_n_next = pd_n_reg;
		psa_next = psa_reg;
		skip_next = skip_reg;
		nop_next = nop_reg;
		cycles_next = cycles_reg;
		op_next = op_reg;
		dest_next = dest_reg;
		addr_next = addr_reg;
		mem_we = 1'b0;
		mem_addr = addr_reg;
		mem_data = alu_res;
		wdt_tick = !psa_reg || (pre_reg == {PRE_W{1'b1}});
		pre_next = pre_reg + 1'b1;
		wdt_next = wdt_tick ? wdt_reg + 1'b1 : wdt_reg;
		if (wdt_tick && wdt_reg == {WDT_W{1'b1}}) begin
			to_n_next = 1'b0;
		end
		case (state_reg)
		ST_IDLE: begin
			if (wr_en && wr_sel == SEL_INSTR && wr_strb[1:0] == 2'h3) begin
				op_next = wr_data[OPC_LSB+:OPC_W];
				dest_next = wr_data[DEST_BIT];
				addr_next = wr_data[FILE_AW-1:0];
				nop_next = skip_reg;
				skip_next = 1'b0;
				state_next = ST_EXEC;
			end else if (wr_en && wr_strb[0]) begin
				if (wr_sel == SEL_ACC) begin
					acc_next = wr_data[7:0];
				end else if (wr_sel == SEL_STATUS) begin
					c_next = wr_data[ST_C_BIT];
					dc_next = wr_data[ST_DC_BIT];
					z_next = wr_data[ST_Z_BIT];
					pd_n_next = wr_data[ST_PD_BIT];
				end else if (wr_sel == SEL_OPTION) begin
					psa_next = wr_data[OPT_PSA_BIT];
				end else if (wr_sel == SEL_FILE) begin
					mem_we = 1'b1;
					mem_addr = wr_addr[FILE_IDX_LSB+:FILE_AW];
					mem_data = wr_data[7:0];
				end
			end
		end
		ST_EXEC: begin
			state_next = ST_IDLE;
			cycles_next = CYCLES_ONE;
			if (nop_reg) begin
				nop_next = 1'b0;
				cycles_next = CYCLES_TWO;
			end else begin
				case (op_reg)
				OP_CLEAR_REGISTER: begin
					mem_we = 1'b1;
					z_next = 1'b1;
				end
				OP_INVERT_REGISTER, OP_DECREMENT_SKIP_ZERO,
				OP_ADD_ACC_REG: begin
					if (dest_reg) begin
						mem_we = 1'b1;
					end else begin
						acc_next = alu_res;
					end
					z_next = res_zero;
					if (op_reg == OP_ADD_ACC_REG) begin
						c_next = alu_c;
						dc_next = alu_dc;
					end
					if (op_reg == OP_DECREMENT_SKIP_ZERO && res_zero) begin
						skip_next = 1'b1;
					end
				end
				OP_WATCHDOG_CLEAR: begin
					wdt_next = '0;
					if (psa_reg) begin
						pre_next = '0;
					end
					to_n_next = 1'b1;
					pd_n_next = 1'b1;
				end
				OP_COMPARE_ACC_REG: begin
					z_next = res_zero;
					c_next = alu_c;
				end
				OP_DECIMAL_ADJUST: begin
					acc_next = alu_res;
					c_next = alu_c;
				end
				default: begin
					state_next = ST_IDLE;
				end
				endcase
			end
		end
		default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (mem_we) begin
			file_mem[mem_addr] <= mem_data;
		end
		if (!rst_n_in) begin
			state_reg <= ST_IDLE;
			acc_reg <= ACC_RESET;
			c_reg <= 1'b0;
			dc_reg <= 1'b0;
			z_reg <= 1'b0;
			to_n_reg <= 1'b1;
			pd_n_reg <= 1'b1;
			psa_reg <= PSA_RESET;
			skip_reg <= 1'b0;
			nop_reg <= 1'b0;
			cycles_reg <= 2'h0;
			op_reg <= OP_CLEAR_REGISTER;
			dest_reg <= 1'b0;
			addr_reg <= '0;
			wdt_reg <= '0;
			pre_reg <= '0;
		end else begin
			state_reg <= state_next;
			acc_reg <= acc_next;
			c_reg <= c_next;
			dc_reg <= dc_next;
			z_reg <= z_next;
			to_n_reg <= to_n_next;
			pd_n_reg <= pd_n_next;
			psa_reg <= psa_next;
			skip_reg <= skip_next;
			nop_reg <= nop_next;
			cycles_reg <= cycles_next;
			op_reg <= op_next;
			dest_reg <= dest_next;
			addr_reg <= addr_next;
			wdt_reg <= wdt_next;
			pre_reg <= pre_next;
		end
	end

endmodule
`default_nettype wire

//--- design/mie_pkg.sv
package mie_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int AXI_ADDR_W = 12;
	localparam logic [11:0] OFF_INSTR = 12'h000;
	localparam logic [11:0] OFF_ACC = 12'h004;
	localparam logic [11:0] OFF_STATUS = 12'h008;
	localparam logic [11:0] OFF_OPTION = 12'h00c;
	localparam logic [11:0] OFF_WDT = 12'h010;
	localparam logic [11:0] OFF_EXEC = 12'h014;
	localparam logic [2:0] FILE_WINDOW = 3'h1;
	localparam int FILE_WIN_LSB = 9;
	localparam int FILE_IDX_LSB = 2;

	// ----------------------------------------------------------------
	// Instruction word fields and opcodes
	// ----------------------------------------------------------------
	localparam int FILE_AW = 7;
	localparam int OPC_LSB = 8;
	localparam int OPC_W = 3;
	localparam int DEST_BIT = 7;
	localparam logic [2:0] OP_CLEAR_REGISTER = 3'h0;
	localparam logic [2:0] OP_INVERT_REGISTER = 3'h1;
	localparam logic [2:0] OP_WATCHDOG_CLEAR = 3'h2;
	localparam logic [2:0] OP_COMPARE_ACC_REG = 3'h3;
	localparam logic [2:0] OP_DECIMAL_ADJUST = 3'h4;
	localparam logic [2:0] OP_DECREMENT_SKIP_ZERO = 3'h5;
	localparam logic [2:0] OP_ADD_ACC_REG = 3'h6;

	// ----------------------------------------------------------------
	// Status and option bits
	// ----------------------------------------------------------------
	localparam int ST_C_BIT = 0;
	localparam int ST_DC_BIT = 1;
	localparam int ST_Z_BIT = 2;
	localparam int ST_PD_BIT = 3;
	localparam int ST_TO_BIT = 4;
	localparam int OPT_PSA_BIT = 0;
	localparam int EXEC_BUSY_BIT = 0;
	localparam int EXEC_SKIP_BIT = 1;
	localparam int EXEC_CYC_LSB = 4;
	localparam int WDT_PRE_LSB = 16;
	localparam logic [1:0] CYCLES_ONE = 2'h1;
	localparam logic [1:0] CYCLES_TWO = 2'h2;

	// ----------------------------------------------------------------
	// Reset values and arithmetic constants
	// ----------------------------------------------------------------
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic PSA_RESET = 1'b1;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [8:0] BCD_ADJ_LO = 9'h006;
	localparam logic [8:0] BCD_ADJ_HI = 9'h060;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SEL_INSTR, SEL_ACC, SEL_STATUS, SEL_OPTION, SEL_WDT, SEL_EXEC,
		SEL_FILE, SEL_NONE
	} mie_sel_type;

	typedef enum logic {ST_IDLE, ST_EXEC} mie_state_type;

endpackage

//--- design/mie_alu.sv
`timescale 1ns/1ns
`default_nettype none
module mie_alu
	import mie_pkg::*;
(
	input wire logic [2:0] op_in,
	input wire logic [7:0] reg_in,
	input wire logic [7:0] acc_in,
	input wire logic c_in,
	input wire logic dc_in,
	output logic [7:0] result_out,
	output logic c_out,
	output logic dc_out
);

	logic [8:0] wide;
	logic [4:0] low;

	always_comb begin
		wide = 9'h000;
		low = 5'h00;
		result_out = BYTE_ZERO;
		c_out = c_in;
		dc_out = dc_in;
		case (op_in)
		OP_CLEAR_REGISTER: begin
			result_out = BYTE_ZERO;
		end
		OP_INVERT_REGISTER: begin
			result_out = ~reg_in;
		end
		OP_COMPARE_ACC_REG: begin
			wide = {1'b0, reg_in} - {1'b0, acc_in};
			result_out = wide[7:0];
			c_out = ~wide[8];
		end
		OP_DECIMAL_ADJUST: begin
			wide = {1'b0, acc_in};
			if (acc_in[3:0] > BCD_DIGIT_MAX || dc_in) begin
				wide = wide + BCD_ADJ_LO;
			end
			if (wide[7:4] > BCD_DIGIT_MAX || c_in || wide[8]) begin
				wide = wide + BCD_ADJ_HI;
			end
			result_out = wide[7:0];
			c_out = c_in | wide[8];
		end
		OP_DECREMENT_SKIP_ZERO: begin
			result_out = reg_in - BYTE_ONE;
		end
		OP_ADD_ACC_REG: begin
			wide = {1'b0, reg_in} + {1'b0, acc_in};
			low = {1'b0, reg_in[3:0]} + {1'b0, acc_in[3:0]};
			result_out = wide[7:0];
			c_out = wide[8];
			dc_out = low[4];
		end
		default: begin
			result_out = BYTE_ZERO;
		end
		endcase
	end

endmodule
`default_nettype wire

//--- design/mie_axil_slave.sv
`timescale 1ns/1ns
`default_nettype none
module mie_axil_slave
	import mie_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic hold_in,
	output logic wr_en_out,
	output logic [AXI_ADDR_W-1:0] wr_addr_out,
	output logic [31:0] wr_data_out,
	output logic [3:0] wr_strb_out,
	input wire logic wr_err_in,
	output logic [AXI_ADDR_W-1:0] rd_addr_out,
	input wire logic [31:0] rd_data_in,
	input wire logic rd_err_in
);

	logic aw_free_reg, aw_free_next, w_free_reg, w_free_next;
	logic [AXI_ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_fire, ar_fire;

	assign wr_addr_out = awaddr_reg;
	assign wr_data_out = wdata_reg;
	assign wr_strb_out = wstrb_reg;
	assign wr_en_out = wr_fire;
	assign rd_addr_out = s_axi_araddr_in;
	assign s_axi_awready_out = aw_free_reg;
	assign s_axi_wready_out = w_free_reg;
	assign s_axi_bvalid_out = bvalid_reg;
	assign s_axi_bresp_out = bresp_reg;
	assign s_axi_arready_out = arready_reg;
	assign s_axi_rvalid_out = rvalid_reg;
	assign s_axi_rresp_out = rresp_reg;
	assign s_axi_rdata_out = rdata_reg;

	// ----------------------------------------------------------------
	// Write and read channels
	// ----------------------------------------------------------------
	always_comb begin
		wr_fire = !aw_free_reg && !w_free_reg && !bvalid_reg && !hold_in;
		ar_fire = s_axi_arvalid_in && arready_reg;
		aw_free_next = aw_free_reg;
		w_free_next = w_free_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (aw_free_reg && s_axi_awvalid_in) begin
			aw_free_next = 1'b0;
			awaddr_next = s_axi_awaddr_in;
		end
		if (w_free_reg && s_axi_wvalid_in) begin
			w_free_next = 1'b0;
			wdata_next = s_axi_wdata_in;
			wstrb_next = s_axi_wstrb_in;
		end
		if (wr_fire) begin
			bvalid_next = 1'b1;
			bresp_next = wr_err_in ? RESP_SLVERR : RESP_OKAY;
		end
		if (bvalid_reg && s_axi_bready_in) begin
			bvalid_next = 1'b0;
			aw_free_next = 1'b1;
			w_free_next = 1'b1;
		end
		if (ar_fire) begin
			rvalid_next = 1'b1;
			rdata_next = rd_err_in ? 32'h0000_0000 : rd_data_in;
			rresp_next = rd_err_in ? RESP_SLVERR : RESP_OKAY;
		end
		if (rvalid_reg && s_axi_rready_in) begin
			rvalid_next = 1'b0;
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			aw_free_reg <= 1'b1;
			w_free_reg <= 1'b1;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end else begin
			aw_free_reg <= aw_free_next;
			w_free_reg <= w_free_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

endmodule
`default_nettype wire

//--- dv/mie_exec_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module mie_exec_top_properties
	import mie_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0] s_axi_rresp_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	// ----------------------------------------------------------------
	// Response channels
	// ----------------------------------------------------------------
	b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped or changed");
	r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out)
		&& $stable(s_axi_rresp_out))
		else $error("read response dropped or changed");
	r_latency_a: assert property (s_axi_arvalid_in && s_axi_arready_out
		|=> s_axi_rvalid_out)
		else $error("read data not one cycle after address");
	r_cause_a: assert property ($rose(s_axi_rvalid_out) |->
		$past(s_axi_arvalid_in && s_axi_arready_out))
		else $error("read data without address");
	ar_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read address open while data pending");
	err_zero_a: assert property (s_axi_rvalid_out
		&& s_axi_rresp_out == RESP_SLVERR |-> s_axi_rdata_out == 32'h0)
		else $error("error read carries data");
	w_block_a: assert property (s_axi_bvalid_out |->
		!s_axi_awready_out && !s_axi_wready_out)
		else $error("write channels open while response pending");
	b_latency_a: assert property (s_axi_awvalid_in && s_axi_awready_out
		&& s_axi_wvalid_in && s_axi_wready_out |-> ##[1:6] s_axi_bvalid_out)
		else $error("write response late");
	b_code_a: assert property (s_axi_bvalid_out |->
		s_axi_bresp_out == RESP_OKAY || s_axi_bresp_out == RESP_SLVERR)
		else $error("illegal write response code");
	wr_c: cover property (s_axi_bvalid_out && s_axi_bready_in);
	rd_c: cover property (s_axi_rvalid_out && s_axi_rready_in);
	err_c: cover property (s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR);
endmodule
bind mie_exec_top mie_exec_top_properties chk_u (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in),
	.s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
	.s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
	.s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
	.s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
	.s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
	.s_axi_rready_in(s_axi_rready_in)
);
`default_nettype wire

//--- dv/mie_exec_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module mie_exec_top_tb_top
	import mie_pkg::*;
;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [6:0] ix;
	logic [7:0] ca [3] = '{8'h12, 8'h34, 8'h55};
	logic [7:0] cr [3] = '{8'h34, 8'h12, 8'h55};
	logic cz [3] = '{1'b0, 1'b0, 1'b1};
	logic cc [3] = '{1'b1, 1'b0, 1'b1};
	logic [7:0] da [2] = '{8'h28, 8'h90};
	logic [7:0] dr [2] = '{8'h25, 8'h90};
	logic [7:0] de [2] = '{8'h53, 8'h80};
	logic dc [2] = '{1'b0, 1'b1};
	int n_fail = 0;
	int compares = 0;

	mie_exec_top #(.WDT_W(4), .PRE_W(2)) dut_u (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready)
	);

	initial begin
		forever #5 mclk_in = ~mclk_in;
	end

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] rs);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk_in);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
		@(posedge mclk_in);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk_in);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge mclk_in);
	endtask

	task automatic wo(input logic [11:0] a, input logic [31:0] d);
		wr(a, d, r);
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] e,
		input string nm);
		rd(a, v, r);
		chk(nm, e, v);
	endtask

	task automatic issue(input logic [2:0] op, input logic d,
		input logic [6:0] i);
		wr(OFF_INSTR, {21'h0, op, d, i}, r);
	endtask

	function automatic logic [11:0] fa(input logic [6:0] i);
		return {FILE_WINDOW, i, 2'b00};
	endfunction

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk_in);
		n_fail++;
		tally_and_finish;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		@(posedge mclk_in);
		rc(OFF_ACC, 32'h0, "acc_reset");
		rc(OFF_STATUS, 32'h18, "status_reset");
		rc(OFF_OPTION, 32'h1, "option_reset");
		$display("test reset done");
		for (int k = 0; k < 2; k++) begin
			ix = k ? 7'h7f : 7'h00;
			wo(fa(ix), 32'h55);
			wo(OFF_STATUS, 32'h08);
			issue(OP_CLEAR_REGISTER, 1'b1, ix);
			rc(fa(ix), 32'h0, "clear_file");
			rd(OFF_STATUS, v, r);
			chk("clear_z", 32'h1, v[ST_Z_BIT]);
		end
		$display("test clear done");
		wo(fa(7'd6), 32'ha6);
		issue(OP_INVERT_REGISTER, 1'b1, 7'd6);
		rc(fa(7'd6), 32'h59, "invert_file");
		rd(OFF_STATUS, v, r);
		chk("invert_z0", 32'h0, v[ST_Z_BIT]);
		wo(fa(7'd7), 32'hff);
		wo(OFF_ACC, 32'h3c);
		issue(OP_INVERT_REGISTER, 1'b0, 7'd7);
		rc(OFF_ACC, 32'h0, "invert_acc");
		rc(fa(7'd7), 32'hff, "invert_keep");
		rd(OFF_STATUS, v, r);
		chk("invert_z1", 32'h1, v[ST_Z_BIT]);
		$display("test invert done");
		for (int k = 0; k < 3; k++) begin
			wo(OFF_STATUS, {28'h0, 1'b1, ~cz[k], 1'b1, ~cc[k]});
			wo(OFF_ACC, {24'h0, ca[k]});
			wo(fa(7'd30), {24'h0, cr[k]});
			issue(OP_COMPARE_ACC_REG, 1'b1, 7'd30);
			rd(OFF_STATUS, v, r);
			chk("cmp_z", cz[k], v[ST_Z_BIT]);
			chk("cmp_c", cc[k], v[ST_C_BIT]);
			chk("cmp_dc", 32'h1, v[ST_DC_BIT]);
			rc(OFF_ACC, {24'h0, ca[k]}, "cmp_acc");
			rc(fa(7'd30), {24'h0, cr[k]}, "cmp_file");
		end
		$display("test compare done");
		for (int k = 0; k < 2; k++) begin
			wo(OFF_STATUS, 32'h08);
			wo(OFF_ACC, {24'h0, da[k]});
			wo(fa(7'd20), {24'h0, dr[k]});
			issue(OP_ADD_ACC_REG, 1'b0, 7'd20);
			issue(OP_DECIMAL_ADJUST, 1'b0, 7'd0);
			rc(OFF_ACC, {24'h0, de[k]}, "daa_acc");
			rd(OFF_STATUS, v, r);
			chk("daa_c", dc[k], v[ST_C_BIT]);
		end
		$display("test decimal done");
		wo(fa(7'd9), 32'h2);
		wo(fa(7'd10), 32'h77);
		issue(OP_DECREMENT_SKIP_ZERO, 1'b1, 7'd9);
		rc(fa(7'd9), 32'h1, "dec_file");
		rd(OFF_EXEC, v, r);
		chk("dec_noskip", 32'h0, v[EXEC_SKIP_BIT]);
		chk("dec_cyc1", CYCLES_ONE, v[EXEC_CYC_LSB+:2]);
		issue(OP_DECREMENT_SKIP_ZERO, 1'b1, 7'd9);
		rc(fa(7'd9), 32'h0, "dec_zero");
		rd(OFF_STATUS, v, r);
		chk("dec_z", 32'h1, v[ST_Z_BIT]);
		rd(OFF_EXEC, v, r);
		chk("dec_skip", 32'h1, v[EXEC_SKIP_BIT]);
		issue(OP_CLEAR_REGISTER, 1'b1, 7'd10);
		rc(fa(7'd10), 32'h77, "skipped_kept");
		rd(OFF_EXEC, v, r);
		chk("skip_done", 32'h0, v[EXEC_SKIP_BIT]);
		chk("dec_cyc2", CYCLES_TWO, v[EXEC_CYC_LSB+:2]);
		wo(fa(7'd11), 32'h5);
		wo(OFF_ACC, 32'h0);
		issue(OP_DECREMENT_SKIP_ZERO, 1'b0, 7'd11);
		rc(OFF_ACC, 32'h4, "dec_acc");
		rc(fa(7'd11), 32'h5, "dec_keep");
		$display("test decrement done");
		wo(OFF_OPTION, 32'h1);
		repeat (80) @(posedge mclk_in);
		rd(OFF_STATUS, v, r);
		chk("timed_out", 32'h0, v[ST_TO_BIT]);
		wo(OFF_STATUS, 32'h00);
		issue(OP_WATCHDOG_CLEAR, 1'b0, 7'd0);
		rd(OFF_WDT, v, r);
		chk("wdt_cleared", 32'h0, v[3:0]);
		chk("pre_cleared", 32'h1, v[WDT_PRE_LSB+:2]);
		rd(OFF_STATUS, v, r);
		chk("wdc_to", 32'h1, v[ST_TO_BIT]);
		chk("wdc_pd", 32'h1, v[ST_PD_BIT]);
		wo(OFF_OPTION, 32'h0);
		issue(OP_WATCHDOG_CLEAR, 1'b0, 7'd0);
		rd(OFF_WDT, v, r);
		chk("wdt_free", 32'h1, v[3:0]);
		$display("test watchdog done");
		wr(12'h018, 32'h1, r);
		chk("bresp_unmapped", RESP_SLVERR, r);
		rd(12'h018, v, r);
		chk("rresp_unmapped", RESP_SLVERR, r);
		chk("rdata_unmapped", 32'h0, v);
		$display("test unmapped done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
